/* File: hw/pld_config.sv */
// Function
// - bit 7 of 17h disables the PLL, pump offset, ADC dither, cycle slip detector and fast acquisition.
// - feedback integer is 17h bits 6:0 plus 18h bit 4.
// - 18h bit 0 picks fractional (0) or integer (1) divider mode.
// - in manual select mode with 18h bit 5 set, input comes from pins.
// - 18h bit 6 enables charge pump offset, bit 7 ADC dither.
// - 18h bits 3:1 hold charge pump binning for tuning gain.
// - 16h bit 0 enables the cycle slip detector; zero disables it.
// - 16h bits 2:1 hold the cycle slip detector threshold.
// - 16h bit 3 zero-delay setting, 5:4 loop filter, 7:6 pump gain.
// - 19h bits 7:6 hold the phase averager configuration.
// - 19h bits 5:2 set phase filter bandwidth; code 3 is reserved.
// - 19h bit 1 holds the phase correction setting.
// - feedback fraction is three full bytes at 1Ah to 1Ch.
// - second divider integer is 1Dh, 1Eh and 1Fh bits 4:0.
// - 1Fh bit 7 enables revertive return to the preferred input.
// - 1Fh bit 6 forces manual input selection over automatic.
// - 1Fh bit 5 forces the second divider modulator to integer.
// - with its enable set, holdover exit uses fast-lock bandwidth.
`timescale 1ns/10ps
`include "pld_params.svh"

module pld_config (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    output logic reg_hit,
    // loop status from the same clock domain
    input wire logic [7:0] normal_prop_path,
    input wire logic [7:0] normal_int_path_a,
    input wire logic [7:0] normal_int_path_b,
    input wire logic fast_acq_on_exit_en,
    input wire logic holdover_exit,
    input wire logic loop_locked,
    input wire logic manual_select_mode,
    input wire logic [1:0] auto_input_sel,
    input wire logic [1:0] preferred_input,
    input wire logic preferred_valid,
    // manual input select pins, asynchronous
    input wire logic [1:0] manual_sel_pins,
    // loop controls
    output logic pll_enable,
    output logic [7:0] feedback_int,
    output pld_pkg::pld_div_mode_t feedback_mode,
    output logic [23:0] feedback_frac,
    output logic [20:0] second_div_int,
    output logic second_delta_sigma_int_mode,
    output logic charge_pump_offset_en,
    output logic adc_dither_en,
    output logic [2:0] charge_pump_binning,
    output logic cycle_slip_en,
    output logic [1:0] cycle_slip_threshold,
    output logic zero_delay_buffer_cfg,
    output logic [1:0] loop_filter_cfg,
    output logic [1:0] charge_pump_gain_cfg,
    output logic [1:0] phase_averager_cfg,
    output logic [3:0] phase_filter_bw,
    output logic phase_filter_bw_reserved,
    output logic phase_correction_cfg,
    output logic fast_acq_active,
    output logic [7:0] prop_path_gain,
    output logic [7:0] int_path_gain_a,
    output logic [7:0] int_path_gain_b,
    output logic [1:0] active_input_sel,
    output pld_pkg::pld_sel_src_t active_input_src,
    output logic revertive_en
);

    // ---------------------------------------------------------------
    // register storage
    // ---------------------------------------------------------------
    // one byte per register, ordered by address
    pld_pkg::pld_byte_t regs_r [0:`PLD_NUM_REGS-1];
    logic [3:0] reg_idx;
    logic addr_in_range;

    // index into the array; the map is contiguous so two compares decode it
    assign addr_in_range = (reg_addr >= `PLD_OFS_FIRST) &&
                           (reg_addr <= `PLD_OFS_LAST);
    assign reg_idx = 4'(reg_addr - `PLD_OFS_FIRST);
    assign reg_hit = addr_in_range;

    // plain storage, every field is writable and resets to zero
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `PLD_NUM_REGS; i++) begin
                regs_r[i] <= `PLD_REG_RESET;
            end
        end else if (reg_wr_en && addr_in_range) begin
            regs_r[reg_idx] <= reg_wdata;
        end
    end

    // read data registered one cycle after the request
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `PLD_RDATA_UNMAPPED;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                // unmapped reads answer zero rather than stale data
                reg_rdata <= addr_in_range ? regs_r[reg_idx] :
                             `PLD_RDATA_UNMAPPED;
            end
        end
    end

    // ---------------------------------------------------------------
    // named views of the stored bytes
    // ---------------------------------------------------------------
    // per-register aliases keep the field logic readable
    pld_pkg::pld_byte_t fast_prop_q;
    pld_pkg::pld_byte_t fast_int_a_q;
    pld_pkg::pld_byte_t fast_int_b_q;
    pld_pkg::pld_byte_t cslip_q;
    pld_pkg::pld_byte_t fb_int_q;
    pld_pkg::pld_byte_t misc_q;
    pld_pkg::pld_byte_t phase_q;
    pld_pkg::pld_byte_t div2_ctrl_q;
    logic master_dis;

    // fixed slots; the offsets are constants so no decode logic results
    assign fast_prop_q = regs_r[4'(`PLD_OFS_FAST_PROP - `PLD_OFS_FIRST)];
    assign fast_int_a_q = regs_r[4'(`PLD_OFS_FAST_INT_A - `PLD_OFS_FIRST)];
    assign fast_int_b_q = regs_r[4'(`PLD_OFS_FAST_INT_B - `PLD_OFS_FIRST)];
    assign cslip_q = regs_r[4'(`PLD_OFS_CSLIP_MISC - `PLD_OFS_FIRST)];
    assign fb_int_q = regs_r[4'(`PLD_OFS_FB_INT_DIS - `PLD_OFS_FIRST)];
    assign misc_q = regs_r[4'(`PLD_OFS_PLL_MISC - `PLD_OFS_FIRST)];
    assign phase_q = regs_r[4'(`PLD_OFS_PHASE_CORR - `PLD_OFS_FIRST)];
    assign div2_ctrl_q = regs_r[4'(`PLD_OFS_DIV2_CTRL - `PLD_OFS_FIRST)];
    assign master_dis = fb_int_q[`PLD_BIT_MASTER_DIS];

    // ---------------------------------------------------------------
    // synchroniser for the manual select pins
    // ---------------------------------------------------------------
    // two stages; selection logic reads only the second
    logic [1:0] man_pins_meta_r;
    logic [1:0] man_pins_r;

    // the first stage feeds the second stage only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            man_pins_meta_r <= 2'h0;
            man_pins_r <= 2'h0;
        end else begin
            man_pins_meta_r <= manual_sel_pins;
            man_pins_r <= man_pins_meta_r;
        end
    end

    // ---------------------------------------------------------------
    // fast acquisition tracking
    // ---------------------------------------------------------------
    // internal flag runs one cycle ahead of fast_acq_active
    logic fast_acq_r;
    logic fast_acq_set;

    // a disabled loop must not start fast acquisition
    assign fast_acq_set = holdover_exit && fast_acq_on_exit_en && !master_dis;

    // set on holdover exit, cleared by lock; a set in the same cycle wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_acq_r <= 1'b0;
        end else if (fast_acq_set) begin
            fast_acq_r <= 1'b1;
        end else if (loop_locked || master_dis) begin
            fast_acq_r <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // input clock selection
    // ---------------------------------------------------------------
    // next selection, settled before the registering edge
    pld_pkg::pld_sel_src_t sel_src_nxt;
    logic manual_mode;
    logic [1:0] sel_nxt;

    // the register force behaves like the manual mode strap
    assign manual_mode = manual_select_mode ||
                         div2_ctrl_q[`PLD_BIT_FORCE_MAN];

    // manual choice outranks revertive, revertive outranks automatic
    always_comb begin
        sel_src_nxt = pld_pkg::PLD_SEL_AUTO;
        sel_nxt = auto_input_sel;
        if (manual_mode) begin
            if (misc_q[`PLD_BIT_MAN_PINS]) begin
                sel_src_nxt = pld_pkg::PLD_SEL_MAN_PINS;
                sel_nxt = man_pins_r;
            end else begin
                // without the pin select the preferred input stands
                sel_src_nxt = pld_pkg::PLD_SEL_MAN_REG;
                sel_nxt = preferred_input;
            end
        end else if (div2_ctrl_q[`PLD_BIT_REVERTIVE] && preferred_valid) begin
            sel_src_nxt = pld_pkg::PLD_SEL_PREFERRED;
            sel_nxt = preferred_input;
        end
    end

    // selection is registered so the clock mux sees no glitches
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_input_sel <= 2'h0;
            active_input_src <= pld_pkg::PLD_SEL_AUTO;
        end else begin
            active_input_sel <= sel_nxt;
            active_input_src <= sel_src_nxt;
        end
    end

    // ---------------------------------------------------------------
    // divider controls
    // ---------------------------------------------------------------
    // divider values stay visible while disabled; only pll_enable is gated
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pll_enable <= 1'b0;
            feedback_int <= 8'h00;
            feedback_mode <= pld_pkg::PLD_MODE_FRAC;
            feedback_frac <= 24'h000000;
            second_div_int <= 21'h000000;
            second_delta_sigma_int_mode <= 1'b0;
            revertive_en <= 1'b0;
        end else begin
            pll_enable <= !master_dis;
            feedback_int <= {misc_q[`PLD_BIT_FB_INT_HI],
                             fb_int_q[6:0]};
            feedback_mode <= pld_pkg::pld_div_mode_t'(
                misc_q[`PLD_BIT_INT_MODE]);
            feedback_frac <= {
                regs_r[4'(`PLD_OFS_FB_FRAC4 - `PLD_OFS_FIRST)],
                regs_r[4'(`PLD_OFS_FB_FRAC3 - `PLD_OFS_FIRST)],
                regs_r[4'(`PLD_OFS_FB_FRAC2 - `PLD_OFS_FIRST)]};
            second_div_int <= {
                div2_ctrl_q[4:0],
                regs_r[4'(`PLD_OFS_DIV2_INT2 - `PLD_OFS_FIRST)],
                regs_r[4'(`PLD_OFS_DIV2_INT1 - `PLD_OFS_FIRST)]};
            second_delta_sigma_int_mode <=
                div2_ctrl_q[`PLD_BIT_DIV2_INT_MODE];
            revertive_en <= div2_ctrl_q[`PLD_BIT_REVERTIVE];
        end
    end

    // ---------------------------------------------------------------
    // charge pump and converter controls
    // ---------------------------------------------------------------
    // enables drop while the PLL is disabled; codes pass unchanged
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_pump_offset_en <= 1'b0;
            adc_dither_en <= 1'b0;
            charge_pump_binning <= 3'h0;
            charge_pump_gain_cfg <= 2'h0;
        end else begin
            charge_pump_offset_en <= misc_q[`PLD_BIT_PUMP_OFFSET] &&
                                     !master_dis;
            adc_dither_en <= misc_q[`PLD_BIT_ADC_DITHER] &&
                             !master_dis;
            charge_pump_binning <= misc_q[3:1];
            charge_pump_gain_cfg <= cslip_q[7:6];
        end
    end

    // ---------------------------------------------------------------
    // cycle slip detector and loop filter controls
    // ---------------------------------------------------------------
    // threshold and filter codes pass through even while disabled
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cycle_slip_en <= 1'b0;
            cycle_slip_threshold <= 2'h0;
            zero_delay_buffer_cfg <= 1'b0;
            loop_filter_cfg <= 2'h0;
        end else begin
            // detector also stops with the rest of the PLL
            cycle_slip_en <= cslip_q[`PLD_BIT_CSLIP_EN] &&
                             !master_dis;
            cycle_slip_threshold <= cslip_q[2:1];
            zero_delay_buffer_cfg <= cslip_q[`PLD_BIT_ZERO_DELAY];
            loop_filter_cfg <= cslip_q[5:4];
        end
    end

    // ---------------------------------------------------------------
    // phase path controls
    // ---------------------------------------------------------------
    // high while software holds the reserved bandwidth code
    logic bw_reserved;

    // the stored byte keeps the code so it still reads back
    assign bw_reserved = (phase_q[5:2] == `PLD_BW_RESERVED);

    // the reserved code is never passed on; the filter gets a safe code
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_averager_cfg <= 2'h0;
            phase_filter_bw <= 4'h0;
            phase_filter_bw_reserved <= 1'b0;
            phase_correction_cfg <= 1'b0;
        end else begin
            phase_averager_cfg <= phase_q[7:6];
            phase_filter_bw <= bw_reserved ? `PLD_BW_SAFE :
                               phase_q[5:2];
            phase_filter_bw_reserved <= bw_reserved;
            phase_correction_cfg <= phase_q[`PLD_BIT_PHASE_CORR];
        end
    end

    // ---------------------------------------------------------------
    // loop gain selection
    // ---------------------------------------------------------------
    // fast gains replace normal ones only while acquisition is running
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_acq_active <= 1'b0;
            prop_path_gain <= 8'h00;
            int_path_gain_a <= 8'h00;
            int_path_gain_b <= 8'h00;
        end else begin
            fast_acq_active <= fast_acq_r;
            prop_path_gain <= fast_acq_r ? fast_prop_q :
                              normal_prop_path;
            int_path_gain_a <= fast_acq_r ? fast_int_a_q :
                               normal_int_path_a;
            int_path_gain_b <= fast_acq_r ? fast_int_b_q :
                               normal_int_path_b;
        end
    end

endmodule : pld_config

/* File: hw/pld_params.svh */
`ifndef PLD_PARAMS_SVH
`define PLD_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PLD_OFS_FAST_PROP     8'h13
`define PLD_OFS_FAST_INT_A    8'h14
`define PLD_OFS_FAST_INT_B    8'h15
`define PLD_OFS_CSLIP_MISC    8'h16
`define PLD_OFS_FB_INT_DIS    8'h17
`define PLD_OFS_PLL_MISC      8'h18
`define PLD_OFS_PHASE_CORR    8'h19
`define PLD_OFS_FB_FRAC2      8'h1A
`define PLD_OFS_FB_FRAC3      8'h1B
`define PLD_OFS_FB_FRAC4      8'h1C
`define PLD_OFS_DIV2_INT1     8'h1D
`define PLD_OFS_DIV2_INT2     8'h1E
`define PLD_OFS_DIV2_CTRL     8'h1F
`define PLD_OFS_FIRST         8'h13
`define PLD_OFS_LAST          8'h1F
`define PLD_NUM_REGS          13

// ---------------------------------------------------------------
// reset values and field positions
// ---------------------------------------------------------------
`define PLD_REG_RESET         8'h00
`define PLD_RDATA_UNMAPPED    8'h00
`define PLD_BIT_CSLIP_EN      0
`define PLD_BIT_ZERO_DELAY    3
`define PLD_BIT_MASTER_DIS    7
`define PLD_BIT_INT_MODE      0
`define PLD_BIT_FB_INT_HI     4
`define PLD_BIT_MAN_PINS      5
`define PLD_BIT_PUMP_OFFSET   6
`define PLD_BIT_ADC_DITHER    7
`define PLD_BIT_PHASE_CORR    1
`define PLD_BIT_DIV2_INT_MODE 5
`define PLD_BIT_FORCE_MAN     6
`define PLD_BIT_REVERTIVE     7
`define PLD_BW_RESERVED       4'h3
`define PLD_BW_SAFE           4'h0

`endif

/* File: hw/pld_pkg.sv */
package pld_pkg;

    // feedback divider operating mode, encoded as the mode bit
    typedef enum logic {
        PLD_MODE_FRAC = 1'b0,
        PLD_MODE_INT  = 1'b1
    } pld_div_mode_t;

    // where the active input clock comes from
    typedef enum logic [1:0] {
        PLD_SEL_AUTO      = 2'b00,
        PLD_SEL_PREFERRED = 2'b01,
        PLD_SEL_MAN_PINS  = 2'b11,
        PLD_SEL_MAN_REG   = 2'b10
    } pld_sel_src_t;

    typedef logic [7:0] pld_byte_t;

endpackage : pld_pkg

/* File: sim/pld_config_props.sv */
`timescale 1ns/10ps

// ---------------------------------------------------------------
// register bank checker
// ---------------------------------------------------------------
module pld_config_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rd_valid,
    input wire logic reg_hit,
    // loop side
    input wire logic [7:0] normal_prop_path,
    input wire logic fast_acq_on_exit_en,
    input wire logic holdover_exit,
    input wire logic pll_enable,
    input wire logic [7:0] feedback_int,
    input wire pld_pkg::pld_div_mode_t feedback_mode,
    input wire logic charge_pump_offset_en,
    input wire logic adc_dither_en,
    input wire logic cycle_slip_en,
    input wire logic [3:0] phase_filter_bw,
    input wire logic phase_filter_bw_reserved,
    input wire logic fast_acq_active,
    input wire logic [7:0] prop_path_gain,
    input wire logic revertive_en
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // a write taken at one address
    sequence s_wr(logic [7:0] a);
        reg_wr_en && reg_addr == a;
    endsequence

    // guarded so a disable written the edge before is not missed
    sequence s_fast_req;
        holdover_exit && fast_acq_on_exit_en && pll_enable &&
            !$past(reg_wr_en && reg_addr == 8'h17);
    endsequence

    a_read_valid: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read valid missing");
    a_unmapped_zero: assert property (
        reg_rd_en && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_master_off: assert property (
        s_wr(8'h17) ##0 reg_wdata[7] |=> ##1 !pll_enable && !cycle_slip_en)
        else $error("disable did not take effect");
    a_gated_on: assert property (
        cycle_slip_en || charge_pump_offset_en || adc_dither_en |->
        pll_enable)
        else $error("function active while disabled");
    a_int_field: assert property (
        s_wr(8'h17) |=> ##1 feedback_int[6:0] == $past(reg_wdata[6:0], 2))
        else $error("feedback integer mismatch");
    a_mode_bit: assert property (
        s_wr(8'h18) |=> ##1 feedback_mode == $past(reg_wdata[0], 2))
        else $error("divider mode mismatch");
    a_bw_spare: assert property (
        phase_filter_bw_reserved |-> phase_filter_bw == 4'h0)
        else $error("reserved bandwidth passed on");
    a_fast_entry: assert property (
        s_fast_req |-> ##2 fast_acq_active)
        else $error("fast acquisition not entered");
    a_gain_normal: assert property (
        !fast_acq_active && $past(rst_n) |->
        prop_path_gain == $past(normal_prop_path))
        else $error("normal gain not used");
    a_revert_bit: assert property (
        s_wr(8'h1F) |=> ##1 revertive_en == $past(reg_wdata[7], 2))
        else $error("revertive enable mismatch");
endmodule : pld_config_props

/* File: sim/tb_pll_loop_divider_config.sv */
`timescale 1ns/10ps

module tb_pll_loop_divider_config;
    // ---------------------------------------------------------------
    // stimulus and observed signals
    // ---------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
    logic reg_wr_en = 1'b0, reg_rd_en = 1'b0;
    logic [7:0] normal_prop_path = 8'h11, normal_int_path_a = 8'h22;
    logic [7:0] normal_int_path_b = 8'h33;
    logic fast_acq_on_exit_en = 1'b0, holdover_exit = 1'b0;
    logic loop_locked = 1'b0, manual_select_mode = 1'b0;
    logic preferred_valid = 1'b0;
    logic [1:0] auto_input_sel = 2'h1, preferred_input = 2'h2;
    logic [1:0] manual_sel_pins = 2'h3;
    logic [7:0] reg_rdata, feedback_int, prop_path_gain;
    logic [7:0] int_path_gain_a, int_path_gain_b;
    logic reg_rd_valid, reg_hit, pll_enable, second_delta_sigma_int_mode;
    logic charge_pump_offset_en, adc_dither_en, cycle_slip_en;
    logic zero_delay_buffer_cfg, phase_filter_bw_reserved;
    logic phase_correction_cfg, fast_acq_active, revertive_en;
    logic [23:0] feedback_frac;
    logic [20:0] second_div_int;
    logic [2:0] charge_pump_binning;
    logic [1:0] cycle_slip_threshold, loop_filter_cfg, charge_pump_gain_cfg;
    logic [1:0] phase_averager_cfg, active_input_sel;
    logic [3:0] phase_filter_bw;
    pld_pkg::pld_div_mode_t feedback_mode;
    pld_pkg::pld_sel_src_t active_input_src;
    int n_fail = 0;
    int tests_run = 0;

    // free-running 40 MHz clock
    always #12.5 core_clk = ~core_clk;

    pld_config uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr_en,
        .reg_rd_en, .reg_rdata, .reg_rd_valid, .reg_hit, .normal_prop_path,
        .normal_int_path_a, .normal_int_path_b, .fast_acq_on_exit_en,
        .holdover_exit, .loop_locked, .manual_select_mode, .auto_input_sel,
        .preferred_input, .preferred_valid, .manual_sel_pins, .pll_enable,
        .feedback_int, .feedback_mode, .feedback_frac, .second_div_int,
        .second_delta_sigma_int_mode, .charge_pump_offset_en, .adc_dither_en,
        .charge_pump_binning, .cycle_slip_en, .cycle_slip_threshold,
        .zero_delay_buffer_cfg, .loop_filter_cfg, .charge_pump_gain_cfg,
        .phase_averager_cfg, .phase_filter_bw, .phase_filter_bw_reserved,
        .phase_correction_cfg, .fast_acq_active, .prop_path_gain,
        .int_path_gain_a, .int_path_gain_b, .active_input_sel,
        .active_input_src, .revertive_en);

    // ---------------------------------------------------------------
    // shared helpers
    // ---------------------------------------------------------------
    task chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // inputs move 2 ns after the edge so no race with the design
    task tick;
        @(posedge core_clk);
        #2;
    endtask : tick

    // an idle cycle after each write keeps the strobe a clean pulse
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        tick();
        reg_wr_en = 1'b0;
        tick();
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd_en = 1'b1;
        tick();
        reg_rd_en = 1'b0;
        chk(reg_rd_valid, 1'b1);
        chk(reg_rdata, exp);
        chk(reg_hit, a >= 8'h13 && a <= 8'h1F);
        tick();
    endtask : rd

    task close_out;
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task t_regs;
        for (int i = 0; i < 13; i++) rd(8'h13 + i[7:0], 8'h00);
        chk(pll_enable, 1'b1);
        for (int i = 0; i < 13; i++) wr(8'h13 + i[7:0], 8'hC3 ^ i[7:0]);
        wr(8'h12, 8'hFF);
        wr(8'h20, 8'hFF);
        rd(8'h12, 8'h00);
        rd(8'h20, 8'h00);
        for (int i = 0; i < 13; i++)
            rd(8'h13 + i[7:0], 8'hC3 ^ i[7:0]);
        $display("test regs done");
    endtask : t_regs

    task t_fields;
        wr(8'h16, 8'h9D);
        wr(8'h17, 8'h35);
        wr(8'h18, 8'hDB);
        wr(8'h19, 8'hD6);
        wr(8'h1A, 8'h12);
        wr(8'h1B, 8'h34);
        wr(8'h1C, 8'h56);
        wr(8'h1D, 8'h9A);
        wr(8'h1E, 8'hBC);
        wr(8'h1F, 8'h36);
        chk(feedback_int, 8'hB5);
        chk(feedback_mode, 1'b1);
        chk({charge_pump_offset_en, adc_dither_en}, 2'h3);
        chk(charge_pump_binning, 3'h5);
        chk(cycle_slip_en, 1'b1);
        chk(cycle_slip_threshold, 2'h2);
        chk({zero_delay_buffer_cfg, loop_filter_cfg, charge_pump_gain_cfg},
            5'h16);
        chk(phase_averager_cfg, 2'h3);
        chk(phase_filter_bw, 4'h5);
        chk(phase_correction_cfg, 1'b1);
        chk(feedback_frac, 24'h563412);
        chk(second_div_int, 21'h16BC9A);
        chk(second_delta_sigma_int_mode, 1'b1);
        wr(8'h17, 8'hB5);
        chk({pll_enable, cycle_slip_en, charge_pump_offset_en},
            3'h0);
        chk({adc_dither_en, feedback_int}, 9'h0B5);
        fast_acq_on_exit_en = 1'b1;
        holdover_exit = 1'b1;
        tick();
        holdover_exit = 1'b0;
        tick();
        tick();
        chk(fast_acq_active, 1'b0);
        wr(8'h17, 8'h35);
        wr(8'h18, 8'h00);
        chk({pll_enable, feedback_mode}, 2'h2);
        wr(8'h19, 8'h0C);
        chk({phase_filter_bw_reserved, phase_filter_bw}, 5'h10);
        rd(8'h19, 8'h0C);
        wr(8'h19, 8'h10);
        chk({phase_filter_bw_reserved, phase_filter_bw}, 5'h04);
        $display("test fields done");
    endtask : t_fields

    task t_fast;
        wr(8'h13, 8'hA1);
        wr(8'h14, 8'hA2);
        wr(8'h15, 8'hA3);
        chk({prop_path_gain, int_path_gain_a}, 16'h1122);
        holdover_exit = 1'b1;
        tick();
        holdover_exit = 1'b0;
        tick();
        chk(fast_acq_active, 1'b1);
        chk({prop_path_gain, int_path_gain_a, int_path_gain_b},
            24'hA1A2A3);
        loop_locked = 1'b1;
        tick();
        loop_locked = 1'b0;
        tick();
        tick();
        chk({fast_acq_active, prop_path_gain, int_path_gain_b},
            17'h01133);
        fast_acq_on_exit_en = 1'b0;
        holdover_exit = 1'b1;
        tick();
        holdover_exit = 1'b0;
        tick();
        tick();
        chk(fast_acq_active, 1'b0);
        $display("test fast done");
    endtask : t_fast

    task t_select;
        chk(active_input_sel, 2'h1);
        chk(active_input_src, pld_pkg::PLD_SEL_AUTO);
        wr(8'h1F, 8'h40);
        chk(active_input_sel, 2'h2);
        chk(active_input_src, pld_pkg::PLD_SEL_MAN_REG);
        wr(8'h18, 8'h20);
        chk(active_input_sel, 2'h3);
        chk(active_input_src, pld_pkg::PLD_SEL_MAN_PINS);
        manual_sel_pins = 2'h0;
        repeat (4) tick();
        chk(active_input_sel, 2'h0);
        wr(8'h1F, 8'h80);
        preferred_valid = 1'b1;
        tick();
        tick();
        chk({revertive_en, active_input_sel}, 3'h6);
        chk(active_input_src, pld_pkg::PLD_SEL_PREFERRED);
        preferred_valid = 1'b0;
        manual_select_mode = 1'b1;
        tick();
        tick();
        chk(active_input_sel, 2'h0);
        $display("test select done");
    endtask : t_select

    // ---------------------------------------------------------------
    // main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        #2;
        rst_n = 1'b1;
        tick();
        t_regs();
        t_fields();
        t_fast();
        t_select();
        close_out();
    end

    // whole run needs about 150 cycles, well inside this span
    initial begin
        #50000;
        n_fail++;
        close_out();
    end
endmodule : tb_pll_loop_divider_config

bind pld_config pld_config_props u_props (.core_clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr_en, .reg_rd_en, .reg_rdata, .reg_rd_valid, .reg_hit,
    .normal_prop_path, .fast_acq_on_exit_en, .holdover_exit, .pll_enable,
    .feedback_int, .feedback_mode, .charge_pump_offset_en, .adc_dither_en,
    .cycle_slip_en, .phase_filter_bw, .phase_filter_bw_reserved,
    .fast_acq_active, .prop_path_gain, .revertive_en);
